// file: rtl/hbw_zws_xbuf.v
// zero-wait-state decision and x-bus data buffer pin multiplexing
`timescale 1ns/1ps
`default_nettype none
`include "hbw_consts.vh"

////////////////////////////////////////////////////////////////////////////////
// Function
// R1 - pull zero-wait output low when access may finish without wait states
// R2 - never pull it low on configuration register access, isolation included
// R3 - never pull it low on parallel port access in standard or EPP 1.9 mode
// R4 - always pull it low on parallel port access in ECP mode
// R5 - in EPP 1.7 mode bit 3 of second-level control decides
// R6 - second-level control reached by index at base+403h, data at base+404h
// R7 - for all other decoded addresses bit 0 of general config one decides
// R8 - bit 4 of general config one selects buffer or alternate pin functions
// R9 - unselected input function on each shared pin is held high internally
// R10 - buffer data lines enabled only while buffer chip select is active
// R11 - buffer read command sets drive direction, read data goes toward host
// R12 - fixed pairing of buffer signals with alternate functions on the pins
// R13 - buffer enable bit loaded from the strap pin during reset
// R14 - drive host data only with chip select and read both active
module hbw_zws_xbuf (
  input  wire       i_core_clk,
  input  wire       i_rstn,
  // host access decode, same clock domain
  input  wire       i_host_access,
  input  wire       i_tgt_cfg_regs,
  input  wire       i_isolation_state,
  input  wire       i_tgt_parport,
  input  wire       i_tgt_other,
  input  wire [2:0] i_pp_mode,
  input  wire [7:0] i_host_wdata,
  // configuration index/data pair
  input  wire       i_cfg_index_wr,
  input  wire       i_cfg_data_wr,
  input  wire       i_cfg_data_rd,
  output reg  [7:0] o_cfg_rdata,
  // parallel port second-level index (base+403h) and data (base+404h)
  input  wire       i_pp_index_wr,
  input  wire       i_pp_data_wr,
  input  wire       i_pp_data_rd,
  output reg  [7:0] o_pp_rdata,
  // zero-wait open-drain pin
  output reg        o_zero_wait_out_n,
  output reg        o_zero_wait_oe,
  // strap
  input  wire       i_buffer_enable_strap,
  // shared input pins
  input  wire       i_pin_cs_ring,
  input  wire       i_pin_rd_id3,
  // shared data pins
  input  wire [7:0] i_xd_pin,
  output reg  [7:0] o_xd_pin,
  output reg  [7:0] o_xd_oe,
  // host side data of the buffer
  input  wire [7:0] i_host_data,
  output reg  [7:0] o_host_data,
  output reg        o_host_data_oe,
  // internal copies of shared inputs
  output reg        o_xbuf_chip_sel_n,
  output reg        o_xbuf_read_cmd_n,
  output reg        o_ring_ind_n,
  output reg        o_ident_bit3_in,
  output reg  [7:0] o_alt_in,
  // alternate function drive
  input  wire       i_gp_chip_sel_one,
  input  wire       i_gp_chip_sel_two,
  input  wire [7:2] i_alt_out,
  input  wire [7:2] i_alt_oe,
  // configuration state
  output reg        o_xbuf_enabled
);

  function blk_hi;
    input sel;
    input v;
    begin
      blk_hi = sel ? v : 1'b1;
    end
  endfunction

  function [7:0] blk_hi8;
    input       sel;
    input [7:0] v;
    begin
      blk_hi8 = sel ? v : `HBW_BYTE_ONES;
    end
  endfunction

  function idx_hit;
    input [7:0] idx;
    input [7:0] want;
    begin
      idx_hit = (idx == want);
    end
  endfunction

  // reset image of general config one: strap level in the buffer enable bit
  function [7:0] buffer_enable_strap_rst_val;
    input     strap;
    reg [7:0] v;
    begin
      v                    = `HBW_BUFFER_ENABLE_STRAP_RST;
      v[`HBW_BUFFER_ENABLE_STRAP_XDB_BIT] = strap;
      buffer_enable_strap_rst_val         = v;
    end
  endfunction

  // mode codes outside the four known ones never shorten an access
  function pp_mode_zws;
    input [2:0] mode;
    input       ctrl_bit;
    begin
      case (mode)
        `HBW_PP_ECP:   pp_mode_zws = 1'b1; // R4
        `HBW_PP_EPP17: pp_mode_zws = ctrl_bit; // R5
        `HBW_PP_SPP:   pp_mode_zws = 1'b0; // R3
        `HBW_PP_EPP19: pp_mode_zws = 1'b0; // R3
        default:       pp_mode_zws = 1'b0;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  reg       strap_s1_reg;
  reg       strap_s2_reg;
  reg       csr_s1_reg;
  reg       csr_s2_reg;
  reg       rdi_s1_reg;
  reg       rdi_s2_reg;
  reg [7:0] xd_s1_reg;
  reg [7:0] xd_s2_reg;
  reg [7:0] hd_s1_reg;
  reg [7:0] hd_s2_reg;

  always @(posedge i_core_clk) begin
    if (!i_rstn) begin
      csr_s1_reg   <= 1'b1;
      csr_s2_reg   <= 1'b1;
      rdi_s1_reg   <= 1'b1;
      rdi_s2_reg   <= 1'b1;
      xd_s1_reg    <= `HBW_BYTE_ONES;
      xd_s2_reg    <= `HBW_BYTE_ONES;
      hd_s1_reg    <= `HBW_BYTE_ZERO;
      hd_s2_reg    <= `HBW_BYTE_ZERO;
    end else begin
      csr_s1_reg   <= i_pin_cs_ring;
      csr_s2_reg   <= csr_s1_reg;
      rdi_s1_reg   <= i_pin_rd_id3;
      rdi_s2_reg   <= rdi_s1_reg;
      xd_s1_reg    <= i_xd_pin;
      xd_s2_reg    <= xd_s1_reg;
      hd_s1_reg    <= i_host_data;
      hd_s2_reg    <= hd_s1_reg;
    end
  end

  // the strap pair runs through reset, so the level is past both stages
  // when the reset load takes it; a reset here would always load a zero
  always @(posedge i_core_clk) begin
    strap_s1_reg <= i_buffer_enable_strap;
    strap_s2_reg <= strap_s1_reg;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // configuration registers

  reg [7:0] cfg_index_reg;
  reg [7:0] buffer_enable_strap_reg;
  reg [7:0] pp_index_reg;
  reg [7:0] ctrl2_reg;

  wire      buffer_enable_strap_hit  = idx_hit(cfg_index_reg, `HBW_BUFFER_ENABLE_STRAP_IDX);
  wire      ctrl2_hit = idx_hit(pp_index_reg, `HBW_PP_CTRL2_IDX);

  always @(posedge i_core_clk) begin
    if (!i_rstn) begin
      cfg_index_reg <= `HBW_BYTE_ZERO;
      // strap level from the synchroniser lands while reset is held
      buffer_enable_strap_reg      <= buffer_enable_strap_rst_val(strap_s2_reg); // R13
    end else begin
      if (i_cfg_index_wr) begin
        cfg_index_reg <= i_host_wdata;
      end
      if (i_cfg_data_wr && buffer_enable_strap_hit) begin
        buffer_enable_strap_reg <= i_host_wdata;
      end
    end
  end

  always @(posedge i_core_clk) begin
    if (!i_rstn) begin
      pp_index_reg <= `HBW_BYTE_ZERO;
      ctrl2_reg    <= `HBW_CTRL2_RST;
    end else begin
      if (i_pp_index_wr) begin
        pp_index_reg <= i_host_wdata; // R6
      end
      if (i_pp_data_wr && ctrl2_hit) begin
        ctrl2_reg <= i_host_wdata; // R6
      end
    end
  end

  // unmapped indexes read as zero
  always @(posedge i_core_clk) begin
    if (!i_rstn) begin
      o_cfg_rdata <= `HBW_BYTE_ZERO;
      o_pp_rdata  <= `HBW_BYTE_ZERO;
    end else begin
      if (i_cfg_data_rd) begin
        o_cfg_rdata <= buffer_enable_strap_hit ? buffer_enable_strap_reg : `HBW_BYTE_ZERO;
      end
      if (i_pp_data_rd) begin
        o_pp_rdata <= ctrl2_hit ? ctrl2_reg : `HBW_BYTE_ZERO; // R6
      end
    end
  end

  wire xdb_sel = buffer_enable_strap_reg[`HBW_BUFFER_ENABLE_STRAP_XDB_BIT];

  ////////////////////////////////////////////////////////////////////////////////
  // zero-wait decision

  reg pp_zws;
  reg zws_next;

  // the decision shows one clock after the decode, so the host decode
  // must stand for the whole access or the pin lets go early

  always @* begin
    pp_zws   = pp_mode_zws(i_pp_mode, ctrl2_reg[`HBW_CTRL2_ZWS_BIT]); // R3 R4 R5
    zws_next = 1'b0;
    // configuration access wins over every other target
    if (i_host_access && !i_tgt_cfg_regs && !i_isolation_state) begin // R2
      if (i_tgt_parport) begin
        zws_next = pp_zws;
      end else if (i_tgt_other) begin
        zws_next = buffer_enable_strap_reg[`HBW_BUFFER_ENABLE_STRAP_ZWS_BIT]; // R7
      end
    end
  end

  always @(posedge i_core_clk) begin
    if (!i_rstn) begin
      o_zero_wait_out_n <= 1'b0;
      o_zero_wait_oe    <= 1'b0;
    end else begin
      o_zero_wait_out_n <= 1'b0;
      o_zero_wait_oe    <= zws_next; // R1
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pin multiplexing

  // pin to output is three clocks; a buffer turnaround shorter than that
  // is not followed, the trade for clean synchronised pins
  wire xb_cs_act = xdb_sel && !csr_s2_reg;
  wire xb_rd_act = xdb_sel && !rdi_s2_reg;

  always @(posedge i_core_clk) begin
    if (!i_rstn) begin
      o_xbuf_chip_sel_n <= 1'b1;
      o_xbuf_read_cmd_n <= 1'b1;
      o_ring_ind_n      <= 1'b1;
      o_ident_bit3_in   <= 1'b1;
      o_alt_in          <= `HBW_BYTE_ONES;
      o_xbuf_enabled    <= 1'b0;
    end else begin
      o_xbuf_enabled    <= xdb_sel; // R8
      o_xbuf_chip_sel_n <= blk_hi(xdb_sel, csr_s2_reg); // R9
      o_ring_ind_n      <= blk_hi(!xdb_sel, csr_s2_reg); // R9
      o_xbuf_read_cmd_n <= blk_hi(xdb_sel, rdi_s2_reg); // R9
      o_ident_bit3_in   <= blk_hi(!xdb_sel, rdi_s2_reg); // R9
      o_alt_in          <= blk_hi8(!xdb_sel, xd_s2_reg); // R9
    end
  end

  // data pins and host side of the buffer
  always @(posedge i_core_clk) begin
    if (!i_rstn) begin
      o_xd_pin          <= `HBW_BYTE_ZERO;
      o_xd_oe           <= `HBW_BYTE_ZERO;
      o_host_data       <= `HBW_BYTE_ZERO;
      o_host_data_oe    <= 1'b0;
    end else begin
      if (xdb_sel) begin
        // write toward the x-bus while selected without read
        o_xd_pin       <= hd_s2_reg;
        o_xd_oe        <= (xb_cs_act && !xb_rd_act) ? `HBW_BYTE_ONES : `HBW_BYTE_ZERO; // R10
        o_host_data    <= xd_s2_reg; // R11
        o_host_data_oe <= xb_cs_act && xb_rd_act; // R14
      end else begin
        o_xd_pin       <= {i_alt_out, i_gp_chip_sel_two, i_gp_chip_sel_one}; // R12
        o_xd_oe        <= {i_alt_oe, `HBW_ALT_CS_OE}; // R12
        o_host_data    <= `HBW_BYTE_ZERO;
        o_host_data_oe <= 1'b0; // R10
      end
    end
  end

endmodule
`default_nettype wire

// file: common/hbw_consts.vh
// constants for the host bus zero-wait and x-bus buffer glue
`ifndef HBW_CONSTS_VH
`define HBW_CONSTS_VH

// configuration register indexes
`define HBW_BUFFER_ENABLE_STRAP_IDX        8'h21
`define HBW_PP_CTRL2_IDX    8'h02

// general_config_one field positions
`define HBW_BUFFER_ENABLE_STRAP_ZWS_BIT    0
`define HBW_BUFFER_ENABLE_STRAP_XDB_BIT    4

// parport_second_level_control field positions
`define HBW_CTRL2_ZWS_BIT   3

// reset values
`define HBW_BYTE_ZERO       8'h00
`define HBW_BYTE_ONES       8'hFF
`define HBW_BUFFER_ENABLE_STRAP_RST        8'h00
`define HBW_CTRL2_RST       8'h00

// parallel port mode encodings
`define HBW_PP_SPP          3'h0
`define HBW_PP_EPP17        3'h1
`define HBW_PP_EPP19        3'h2
`define HBW_PP_ECP          3'h3

// chip-select pins of the alternate function are outputs only
`define HBW_ALT_CS_OE       2'h3

`endif

// file: verification/hbw_chk_assertions.sv
// checker for the zero-wait and x-bus buffer outputs
`timescale 1ns/1ps
`default_nettype none
`include "hbw_consts.vh"
module hbw_chk (
  input wire logic       i_core_clk,
  input wire logic       i_rstn,
  input wire logic       i_host_access,
  input wire logic       i_tgt_cfg_regs,
  input wire logic       i_isolation_state,
  input wire logic       i_tgt_parport,
  input wire logic [2:0] i_pp_mode,
  input wire logic       o_zero_wait_out_n,
  input wire logic       o_zero_wait_oe,
  input wire logic       o_xbuf_enabled,
  input wire logic       o_xbuf_chip_sel_n,
  input wire logic [7:0] o_alt_in,
  input wire logic       o_host_data_oe,
  input wire logic [7:0] o_xd_oe
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  wire logic cfg = i_host_access && (i_tgt_cfg_regs || i_isolation_state);
  wire logic pp  = i_host_access && i_tgt_parport && !cfg;
  ////////////////////////////////////////////////////////////////////////////////
  cfg_no_zws_a: assert property (cfg |=> !o_zero_wait_oe)
    else $error("zero wait on config access");
  ecp_zws_a: assert property (pp && i_pp_mode == `HBW_PP_ECP |=> o_zero_wait_oe)
    else $error("no zero wait in ecp mode");
  idle_no_zws_a: assert property (!i_host_access |=> !o_zero_wait_oe)
    else $error("zero wait without access");
  od_low_a: assert property (o_zero_wait_out_n == 1'b0)
    else $error("open drain pin driven high");
  // mode changes need the pin pipeline to drain first
  alt_copy_a: assert property (!o_xbuf_enabled && !$past(o_xbuf_enabled, 4) |-> o_xbuf_chip_sel_n)
    else $error("buffer copy not held high");
  buf_copy_a: assert property (o_xbuf_enabled && $past(o_xbuf_enabled, 4) |-> &o_alt_in)
    else $error("alternate copy not held high");
  alt_cs_a: assert property ($past(i_rstn) && !o_xbuf_enabled && !$past(o_xbuf_enabled, 4) |-> &o_xd_oe[1:0])
    else $error("chip select pins not driven");
  no_fight_a: assert property (!(o_host_data_oe && o_xd_oe != `HBW_BYTE_ZERO))
    else $error("both buffer directions driven");
endmodule
bind hbw_zws_xbuf hbw_chk i_hbw_chk (.*);
`default_nettype wire

// file: verification/hbw_xbus_periph.sv
// x-bus peripheral model on the shared data pins
`timescale 1ns/1ps
`default_nettype none
module hbw_xbus_periph #(parameter logic [7:0] RD_VAL = 8'hA5) (
  input  wire logic [7:0] i_oe,
  input  wire logic [7:0] i_drv,
  input  wire logic       i_sel,
  output logic      [7:0] o_pin
);
  // released bits show RD_VAL while selected for read, else the inverse of i_drv so a stale value never matches
  assign o_pin = (i_oe & i_drv) | (~i_oe & (i_sel ? RD_VAL : ~i_drv));
endmodule
`default_nettype wire

// file: verification/tb.sv
// bench for the zero-wait and x-bus buffer glue
`timescale 1ns/1ps
`default_nettype none
`include "hbw_consts.vh"
module tb;
  logic       i_core_clk = 1'h0, i_rstn = 1'h0, i_host_access = 1'h0, i_tgt_cfg_regs = 1'h0;
  logic       i_isolation_state = 1'h0, i_tgt_parport = 1'h0, i_tgt_other = 1'h0;
  logic       i_cfg_index_wr = 1'h0, i_cfg_data_wr = 1'h0, i_cfg_data_rd = 1'h0;
  logic       i_pp_index_wr = 1'h0, i_pp_data_wr = 1'h0, i_pp_data_rd = 1'h0;
  logic       i_buffer_enable_strap = 1'h1, i_pin_cs_ring = 1'h1, i_pin_rd_id3 = 1'h1;
  logic       i_gp_chip_sel_one = 1'h1, i_gp_chip_sel_two = 1'h0;
  logic [2:0] i_pp_mode = 3'h0;
  logic [7:0] i_host_wdata = 8'h00, i_host_data = 8'h00;
  logic [7:2] i_alt_out = 6'h2A, i_alt_oe = 6'h15;
  wire  [7:0] i_xd_pin, o_cfg_rdata, o_pp_rdata, o_xd_pin, o_xd_oe, o_host_data, o_alt_in;
  wire        o_zero_wait_out_n, o_zero_wait_oe, o_host_data_oe, o_xbuf_chip_sel_n;
  wire        o_xbuf_read_cmd_n, o_ring_ind_n, o_ident_bit3_in, o_xbuf_enabled;
  int         n_errors = 0, compares = 0;
  always #5 i_core_clk = ~i_core_clk;
  hbw_zws_xbuf i_hbw_zws_xbuf (.*);
  hbw_xbus_periph i_hbw_xbus_periph (.i_oe(o_xd_oe), .i_drv(o_xd_pin),
    .i_sel(!i_pin_cs_ring && !i_pin_rd_id3), .o_pin(i_xd_pin));
  task chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task reg_op(input logic pp, input logic w, input logic [7:0] ix, input logic [7:0] d);
    @(posedge i_core_clk);
    {i_host_wdata, i_cfg_index_wr, i_pp_index_wr} <= {ix, !pp, pp};
    @(posedge i_core_clk);
    {i_host_wdata, i_cfg_index_wr, i_pp_index_wr} <= {d, 2'h0};
    {i_cfg_data_wr, i_pp_data_wr, i_cfg_data_rd, i_pp_data_rd} <= {w&!pp, w&pp, !w&!pp, !w&pp};
    @(posedge i_core_clk);
    {i_cfg_data_wr, i_pp_data_wr, i_cfg_data_rd, i_pp_data_rd} <= 4'h0;
    @(posedge i_core_clk);
    #1;
    if (!w) chk(pp ? o_pp_rdata : o_cfg_rdata, d);
  endtask
  task zws(input logic [1:0] ci, input logic p, input logic o, input logic [2:0] m, input logic e);
    @(posedge i_core_clk);
    {i_host_access, i_tgt_cfg_regs, i_isolation_state, i_tgt_parport} <= {1'h1, ci, p};
    {i_tgt_other, i_pp_mode} <= {o, m};
    @(posedge i_core_clk);
    i_host_access <= 1'h0;
    #1;
    chk({6'h00, o_zero_wait_out_n, o_zero_wait_oe}, {7'h00, e});
  endtask
  // pin inputs cross two sync flops, so allow the pipeline to settle
  task pins(input logic cs, input logic rd, input logic [7:0] hd);
    @(posedge i_core_clk);
    {i_pin_cs_ring, i_pin_rd_id3, i_host_data} <= {cs, rd, hd};
    repeat (5) @(posedge i_core_clk);
    #1;
  endtask
  task results;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    #100000;
    n_errors++;
    results;
  end
  initial begin
    repeat (20) @(posedge i_core_clk);
    i_rstn <= 1'h1;
    pins(1'h1, 1'h1, 8'h00);
    chk({7'h00, o_xbuf_enabled}, 8'h01);
    reg_op(1'h0, 1'h1, `HBW_BUFFER_ENABLE_STRAP_IDX, 8'h11);
    zws(2'h0, 1'h0, 1'h1, `HBW_PP_SPP, 1'h1);
    zws(2'h2, 1'h0, 1'h1, `HBW_PP_SPP, 1'h0);
    zws(2'h1, 1'h1, 1'h0, `HBW_PP_ECP, 1'h0);
    reg_op(1'h0, 1'h1, `HBW_BUFFER_ENABLE_STRAP_IDX, 8'h10);
    reg_op(1'h0, 1'h0, `HBW_BUFFER_ENABLE_STRAP_IDX, 8'h10);
    zws(2'h0, 1'h0, 1'h1, `HBW_PP_SPP, 1'h0);
    zws(2'h0, 1'h1, 1'h1, `HBW_PP_ECP, 1'h1);
    zws(2'h0, 1'h1, 1'h0, `HBW_PP_SPP, 1'h0);
    zws(2'h0, 1'h1, 1'h0, `HBW_PP_EPP19, 1'h0);
    zws(2'h0, 1'h1, 1'h0, `HBW_PP_EPP17, 1'h0);
    reg_op(1'h1, 1'h1, `HBW_PP_CTRL2_IDX, 8'h08);
    reg_op(1'h1, 1'h0, `HBW_PP_CTRL2_IDX, 8'h08);
    zws(2'h0, 1'h1, 1'h0, `HBW_PP_EPP17, 1'h1);
    zws(2'h0, 1'h1, 1'h0, `HBW_PP_EPP19, 1'h0);
    reg_op(1'h1, 1'h1, 8'h05, 8'hFF);
    reg_op(1'h1, 1'h0, `HBW_PP_CTRL2_IDX, 8'h08);
    reg_op(1'h1, 1'h0, 8'h05, 8'h00);
    $display("zero wait tests done");
    pins(1'h0, 1'h0, 8'h00);
    chk({o_host_data_oe, 7'h00} | o_xd_oe, 8'h80);
    chk(o_host_data, 8'hA5);
    chk({4'h0, o_ring_ind_n, o_ident_bit3_in, o_xbuf_read_cmd_n, o_xbuf_chip_sel_n}, 8'h0C);
    chk(o_alt_in, 8'hFF);
    pins(1'h0, 1'h1, 8'h3C);
    chk({7'h00, o_host_data_oe} | o_xd_oe, 8'hFF);
    chk(o_xd_pin, 8'h3C);
    pins(1'h1, 1'h1, 8'h3C);
    chk({7'h00, o_host_data_oe} | o_xd_oe, 8'h00);
    reg_op(1'h0, 1'h1, `HBW_BUFFER_ENABLE_STRAP_IDX, 8'h00);
    pins(1'h0, 1'h1, 8'h3C);
    chk(o_xd_pin, 8'hA9);
    chk(o_xd_oe, 8'h57);
    chk({5'h00, o_xbuf_enabled, o_ring_ind_n, o_xbuf_chip_sel_n}, 8'h01);
    pins(1'h0, 1'h0, 8'h3C);
    chk({4'h0, o_ring_ind_n, o_ident_bit3_in, o_xbuf_read_cmd_n, o_xbuf_chip_sel_n}, 8'h03);
    chk(o_alt_in, 8'hA1);
    chk({7'h00, o_host_data_oe}, 8'h00);
    $display("buffer tests done");
    results;
  end
endmodule
`default_nettype wire
